/* rtl/cocd_pkg.sv */
package cocd_pkg;

  // ****************************************************************
  // Image layout
  // ****************************************************************
  localparam int unsigned CTRL_W      = 8;
  localparam int unsigned CMD_W       = 16;
  localparam int unsigned REAL_W      = 32;

  localparam logic [3:0] OFS_ACTION   = 4'h0;
  localparam logic [3:0] OFS_OUTPUT   = 4'h1;
  localparam logic [3:0] OFS_COMMAND  = 4'h2;
  localparam logic [3:0] OFS_VALUE    = 4'h4;
  localparam logic [3:0] OFS_SPARE_A  = 4'h8;
  localparam logic [3:0] OFS_SPARE_B  = 4'hc;

  // Action byte bit positions.
  localparam int unsigned BIT_TARE      = 0;
  localparam int unsigned BIT_UNTARE    = 1;
  localparam int unsigned BIT_CLR_EXT   = 2;
  localparam int unsigned BIT_CLR_LIM1  = 3;
  localparam int unsigned BIT_CLR_LIM2  = 4;
  localparam int unsigned BIT_ADC_STOP  = 7;

  // Output and enable byte bit positions.
  localparam int unsigned BIT_CFG_CLR   = 0;
  localparam int unsigned BIT_SW_A      = 1;
  localparam int unsigned BIT_SW_B      = 2;
  localparam int unsigned BIT_BUS_EN    = 7;

  localparam logic [CTRL_W-1:0] HELD_RESET = 8'h00;
  localparam logic [CMD_W-1:0]  CMD_IDLE   = 16'h0000;

  // Command codes.
  localparam logic [CMD_W-1:0] CMD_TARE_U = 16'h0001;
  localparam logic [CMD_W-1:0] CMD_LOWA_U = 16'h0002;
  localparam logic [CMD_W-1:0] CMD_LOWA_V = 16'h0003;
  localparam logic [CMD_W-1:0] CMD_UPA_U  = 16'h0004;
  localparam logic [CMD_W-1:0] CMD_UPA_V  = 16'h0005;
  localparam logic [CMD_W-1:0] CMD_LOWB_U = 16'h0006;
  localparam logic [CMD_W-1:0] CMD_LOWB_V = 16'h0007;
  localparam logic [CMD_W-1:0] CMD_UPB_U  = 16'h0008;
  localparam logic [CMD_W-1:0] CMD_UPB_V  = 16'h0009;

  typedef enum logic [3:0] {
    TGT_NONE   = 4'b0000,
    TGT_TARE_U = 4'b0001,
    TGT_LOWA_U = 4'b0010,
    TGT_LOWA_V = 4'b0011,
    TGT_UPA_U  = 4'b0100,
    TGT_UPA_V  = 4'b0101,
    TGT_LOWB_U = 4'b0110,
    TGT_LOWB_V = 4'b0111,
    TGT_UPB_U  = 4'b1000,
    TGT_UPB_V  = 4'b1001
  } cocd_target_t;

  // One block of the cyclic output image, offset 0 in the low bits.
  typedef struct packed {
    logic [REAL_W-1:0] spareB;
    logic [REAL_W-1:0] spareA;
    logic [REAL_W-1:0] commandValue;
    logic [CMD_W-1:0]  writeCommand;
    logic [CTRL_W-1:0] outputAndEnableBits;
    logic [CTRL_W-1:0] actionBits;
  } cocd_image_t;

  // One-cycle action pulses toward the measurement channel.
  typedef struct packed {
    logic tare;
    logic untare;
    logic clrExtremeValueStore;
    logic clrPeakHold;
    logic clrLimitOutput1;
    logic clrLimitOutput2;
    logic clrConfigError;
  } cocd_action_t;

  // A decoded value write.
  typedef struct packed {
    logic              write;
    cocd_target_t      target;
    logic [REAL_W-1:0] value;
  } cocd_write_t;

endpackage

/* rtl/cocd_edge_hold.sv */
`timescale 1ns/1ps

module cocd_edge_hold #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // Received value
  input  wire logic         sample,
  input  wire logic [W-1:0] value,
  // Comparison results
  output logic      [W-1:0] held,
  output logic      [W-1:0] rise
);

  logic [W-1:0] held_q;

  // Held copy of the last sampled value; cleared at reset so a bit that is
  // already high in the first image counts as a rising edge.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      held_q <= '0;
    else if (sample)
      held_q <= value;
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_rise
      assign rise[i] = value[i] & ~held_q[i];
    end
  endgenerate

  assign held = held_q;

endmodule

/* rtl/cocd_block_decoder.sv */
`timescale 1ns/1ps
// Overview of operation
// - Action bit 0 rising runs tare once; a held-high bit does nothing more.
// - Action bit 1 rising cancels the active tare.
// - Coupler block: action bit 2 rising clears the extreme value store.
// - Channel block: action bit 2 rising clears peak hold and extreme store.
// - Action bits 3 and 4 rising clear limit outputs 1 and 2.
// - Channel block: output byte bit 0 clears config error; action bit 7 stops ADC.
// - Output byte bits 1 and 2 drive switch outputs A and B when set up.
// - Without bus control enable, all control bits and commands are ignored.
// - Command field write happens only on change from idle to a write code.
// - A command write takes its value from the real field at offset 4.
// - Coupler decodes 1,2,4,6,8 in scaled units; odd codes 3..9 are reserved.
// - Channel adds odd codes 3,5,7,9 as limits in volts.
// - Real fields at offsets 8 and 12 carry no function.
// - Image holds coupler block first, then one block per channel in order.

module cocd_block_decoder (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // Block kind: 0 bus coupler, 1 amplifier channel
  input  wire logic                  chanMode,
  // Received image block
  input  wire logic                  imgValid,
  input  wire cocd_pkg::cocd_image_t img,
  // Switch output setup
  input  wire logic                  outputASetup,
  input  wire logic                  outputBSetup,
  // Actions and state
  output cocd_pkg::cocd_action_t     action_q,
  output logic                       adcStop_q,
  output logic                       busControlEnable_q,
  // Switch outputs
  output logic                       switchOutputA_q,
  output logic                       switchOutputB_q,
  output logic                       switchOwnA_q,
  output logic                       switchOwnB_q,
  // Value writes
  output cocd_pkg::cocd_write_t      write_q
);

  // ****************************************************************
  // Decoding
  // ****************************************************************

  // Reserved and unknown codes decode to no target.
  function automatic cocd_pkg::cocd_target_t decodeCmd(
    input logic [cocd_pkg::CMD_W-1:0] code,
    input logic                       chan
  );
    cocd_pkg::cocd_target_t t;
    t = cocd_pkg::TGT_NONE;
    case (code)
      cocd_pkg::CMD_TARE_U: t = cocd_pkg::TGT_TARE_U;
      cocd_pkg::CMD_LOWA_U: t = cocd_pkg::TGT_LOWA_U;
      cocd_pkg::CMD_UPA_U:  t = cocd_pkg::TGT_UPA_U;
      cocd_pkg::CMD_LOWB_U: t = cocd_pkg::TGT_LOWB_U;
      cocd_pkg::CMD_UPB_U:  t = cocd_pkg::TGT_UPB_U;
      cocd_pkg::CMD_LOWA_V: t = chan ? cocd_pkg::TGT_LOWA_V : cocd_pkg::TGT_NONE;
      cocd_pkg::CMD_UPA_V:  t = chan ? cocd_pkg::TGT_UPA_V : cocd_pkg::TGT_NONE;
      cocd_pkg::CMD_LOWB_V: t = chan ? cocd_pkg::TGT_LOWB_V : cocd_pkg::TGT_NONE;
      cocd_pkg::CMD_UPB_V:  t = chan ? cocd_pkg::TGT_UPB_V : cocd_pkg::TGT_NONE;
      default:              t = cocd_pkg::TGT_NONE;
    endcase
    return t;
  endfunction

  logic [cocd_pkg::CTRL_W-1:0] heldAction;
  logic [cocd_pkg::CTRL_W-1:0] riseAction;
  logic [cocd_pkg::CMD_W-1:0]  heldCmd;
  logic                        busEn;
  logic                        take;
  logic                        cmdFire;
  cocd_pkg::cocd_target_t      cmdTarget;

  // The held values advance on every image, enabled or not, so that
  // taking bus control with an action byte bit already high raises no pulse.
  cocd_edge_hold #(
    .W      (cocd_pkg::CTRL_W)
  ) u_action_edge (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .sample (imgValid),
    .value  (img.actionBits),
    .held   (heldAction),
    .rise   (riseAction)
  );

  cocd_edge_hold #(
    .W      (cocd_pkg::CMD_W)
  ) u_cmd_hold (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .sample (imgValid),
    .value  (img.writeCommand),
    .held   (heldCmd),
    .rise   ()
  );

  assign busEn     = img.outputAndEnableBits[cocd_pkg::BIT_BUS_EN];
  assign take      = imgValid & busEn;
  assign cmdTarget = decodeCmd(img.writeCommand, chanMode);
  // Spare fields at offsets 8 and 12 are never read.
  assign cmdFire   = take && (heldCmd == cocd_pkg::CMD_IDLE)
                     && (cmdTarget != cocd_pkg::TGT_NONE);

  // ****************************************************************
  // Action pulses
  // ****************************************************************

  // Only the named bits are looked at; bits 5 and 6 and the unused
  // output byte bits have no path into any action.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      action_q <= '0;
    else
    begin
      action_q.tare                 <= take & riseAction[cocd_pkg::BIT_TARE];
      action_q.untare               <= take & riseAction[cocd_pkg::BIT_UNTARE];
      action_q.clrExtremeValueStore <= take & riseAction[cocd_pkg::BIT_CLR_EXT];
      action_q.clrPeakHold          <= take & chanMode
                                       & riseAction[cocd_pkg::BIT_CLR_EXT];
      action_q.clrLimitOutput1      <= take & riseAction[cocd_pkg::BIT_CLR_LIM1];
      action_q.clrLimitOutput2      <= take & riseAction[cocd_pkg::BIT_CLR_LIM2];
      action_q.clrConfigError       <= take & chanMode
                                       & img.outputAndEnableBits[cocd_pkg::BIT_CFG_CLR];
    end
  end

  // ADC stop is a level; without bus control the last setting stands.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      adcStop_q <= 1'b0;
    else if (take)
      adcStop_q <= chanMode & img.actionBits[cocd_pkg::BIT_ADC_STOP];
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      busControlEnable_q <= 1'b0;
    else if (imgValid)
      busControlEnable_q <= busEn;
  end

  // ****************************************************************
  // Switch outputs
  // ****************************************************************

  // Ownership tells the output stage whether the bus or local logic
  // drives the switch; the level is kept while the bus does not own it.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      switchOwnA_q    <= 1'b0;
      switchOwnB_q    <= 1'b0;
      switchOutputA_q <= 1'b0;
      switchOutputB_q <= 1'b0;
    end
    else if (imgValid)
    begin
      switchOwnA_q <= busEn & outputASetup;
      switchOwnB_q <= busEn & outputBSetup;
      if (busEn && outputASetup)
        switchOutputA_q <= img.outputAndEnableBits[cocd_pkg::BIT_SW_A];
      if (busEn && outputBSetup)
        switchOutputB_q <= img.outputAndEnableBits[cocd_pkg::BIT_SW_B];
    end
  end

  // ****************************************************************
  // Value writes
  // ****************************************************************

  // Target and value stand until the next write so a slow consumer can
  // still read them after the one-cycle strobe.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_q.write  <= 1'b0;
      write_q.target <= cocd_pkg::TGT_NONE;
      write_q.value  <= '0;
    end
    else
    begin
      write_q.write <= cmdFire;
      if (cmdFire)
      begin
        write_q.target <= cmdTarget;
        write_q.value  <= img.commandValue;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence s_take_rise(int unsigned b);
    imgValid && busEn && img.actionBits[b] && !heldAction[b];
  endsequence

  sequence s_cmd_arm;
    imgValid && busEn && heldCmd == cocd_pkg::CMD_IDLE
      && cmdTarget != cocd_pkg::TGT_NONE;
  endsequence

  a_tare_edge: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_rise(cocd_pkg::BIT_TARE) |=> action_q.tare)
    else $error("tare pulse missing after rising edge");

  a_tare_once: assert property (@(posedge mclk) disable iff (!rst_b)
    action_q.tare |=> !action_q.tare)
    else $error("tare pulse repeated on held bit");

  a_untare_edge: assert property (@(posedge mclk) disable iff (!rst_b)
    action_q.untare |-> $past(imgValid) && $past(busEn)
      && $past(img.actionBits[cocd_pkg::BIT_UNTARE]) && !$past(heldAction[cocd_pkg::BIT_UNTARE]))
    else $error("untare pulse without a rising edge");

  a_peak_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_rise(cocd_pkg::BIT_CLR_EXT) ##1 $past(chanMode)
      |-> action_q.clrPeakHold && action_q.clrExtremeValueStore)
    else $error("channel clear did not clear peak and extremes");

  a_coupler_peak: assert property (@(posedge mclk) disable iff (!rst_b)
    action_q.clrPeakHold |-> $past(chanMode))
    else $error("peak hold cleared in coupler block");

  a_quiet_disabled: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && !busEn |=> action_q == '0 && !write_q.write)
    else $error("action taken without bus control");

  a_cmd_write: assert property (@(posedge mclk) disable iff (!rst_b)
    s_cmd_arm |=> write_q.write && write_q.value == $past(img.commandValue)
      && write_q.target == $past(cmdTarget))
    else $error("command write lost or carried wrong value");

  a_cmd_nonidle: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && heldCmd != cocd_pkg::CMD_IDLE |=> !write_q.write)
    else $error("write without idle before it");

  a_coupler_codes: assert property (@(posedge mclk) disable iff (!rst_b)
    write_q.write && !$past(chanMode) |-> !write_q.target[0]
      || write_q.target == cocd_pkg::TGT_TARE_U)
    else $error("coupler accepted a volt limit code");

  a_switch_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && busEn && outputASetup ##1 1'b1
      |-> switchOwnA_q && switchOutputA_q == $past(img.outputAndEnableBits[cocd_pkg::BIT_SW_A]))
    else $error("switch output A not following bus bit");

  a_adc_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && busEn && !chanMode |=> !adcStop_q)
    else $error("ADC stopped from coupler block");

  sequence s_take_chan;
    imgValid && busEn && chanMode;
  endsequence

  sequence s_take_coupler;
    imgValid && busEn && !chanMode;
  endsequence

  sequence s_held_high(int unsigned b);
    imgValid && heldAction[b];
  endsequence

  a_untare_fire: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_rise(cocd_pkg::BIT_UNTARE) |=> action_q.untare)
    else $error("untare pulse missing after rising edge");

  a_extreme_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_rise(cocd_pkg::BIT_CLR_EXT) |=> action_q.clrExtremeValueStore)
    else $error("extreme store clear missing after rising edge");

  a_limit1_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_rise(cocd_pkg::BIT_CLR_LIM1) |=> action_q.clrLimitOutput1)
    else $error("limit output 1 clear missing after rising edge");

  a_limit2_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_rise(cocd_pkg::BIT_CLR_LIM2) |=> action_q.clrLimitOutput2)
    else $error("limit output 2 clear missing after rising edge");

  a_config_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_chan |=> action_q.clrConfigError
      == $past(img.outputAndEnableBits[cocd_pkg::BIT_CFG_CLR]))
    else $error("config error clear not following its bit");

  a_adc_level: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_chan |=> adcStop_q == $past(img.actionBits[cocd_pkg::BIT_ADC_STOP]))
    else $error("ADC stop not following its bit");

  a_coupler_unused: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_coupler |=> !action_q.clrConfigError && !action_q.clrPeakHold)
    else $error("coupler block acted on an unused bit");

  a_switch_b: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && busEn && outputBSetup ##1 1'b1
      |-> switchOwnB_q && switchOutputB_q == $past(img.outputAndEnableBits[cocd_pkg::BIT_SW_B]))
    else $error("switch output B not following bus bit");

  a_switch_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && !outputASetup |=> !switchOwnA_q && $stable(switchOutputA_q))
    else $error("switch output A driven without setup");

  a_owner_off: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid && !busEn |=> !switchOwnA_q && !switchOwnB_q && $stable(adcStop_q))
    else $error("levels changed without bus control");

  a_enable_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    imgValid |=> busControlEnable_q == $past(busEn))
    else $error("bus control flag not following image");

  a_action_gated: assert property (@(posedge mclk) disable iff (!rst_b)
    action_q != '0 |-> $past(imgValid) && $past(busEn))
    else $error("action pulse without an enabled image");

  a_held_tare: assert property (@(posedge mclk) disable iff (!rst_b)
    s_held_high(cocd_pkg::BIT_TARE) |=> !action_q.tare)
    else $error("tare retriggered by a held bit");

  a_held_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    s_held_high(cocd_pkg::BIT_CLR_EXT) |=> !action_q.clrExtremeValueStore)
    else $error("extreme clear retriggered by a held bit");

  a_write_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    !write_q.write |-> $stable(write_q.target) && $stable(write_q.value))
    else $error("write target or value changed without a write");

  a_write_single: assert property (@(posedge mclk) disable iff (!rst_b)
    write_q.write |=> !write_q.write)
    else $error("write strobe longer than one cycle");

  a_write_gated: assert property (@(posedge mclk) disable iff (!rst_b)
    write_q.write |-> $past(imgValid) && $past(busEn)
      && $past(heldCmd) == cocd_pkg::CMD_IDLE)
    else $error("write without an enabled idle-to-code change");

  a_channel_volt: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_chan ##0 (heldCmd == cocd_pkg::CMD_IDLE && img.writeCommand == cocd_pkg::CMD_LOWB_V)
      |=> write_q.write && write_q.target == cocd_pkg::TGT_LOWB_V)
    else $error("channel volt limit code not written");

  a_coupler_volt: assert property (@(posedge mclk) disable iff (!rst_b)
    s_take_coupler ##0 (img.writeCommand == cocd_pkg::CMD_UPB_V) |=> !write_q.write)
    else $error("coupler wrote on a reserved code");

endmodule

/* sim/cocd_plc_model.sv */
`timescale 1ns/1ps
module cocd_plc_model (
  // Clock
  input  wire logic                  mclk,
  // Image toward the decoder
  output logic                       imgValid,
  output cocd_pkg::cocd_image_t      img
);
  logic [31:0] spareSeq;

  initial
  begin
    imgValid = 1'b0;
    img      = '0;
    spareSeq = 32'h5a5a0f0f;
  end

  // ****************************************************************
  // One block per bus cycle
  // ****************************************************************
  // Spare fields change every image so a decoder that uses them is caught.
  // The model never reads configuration entries, so bus control may stay set.
  task automatic send(input logic [7:0] a, input logic [7:0] b, input logic [15:0] cmd,
                      input logic [31:0] val);
  begin
    @(posedge mclk);
    #1;
    spareSeq = ~spareSeq + 32'h00000001;
    img      = '{spareB: spareSeq, spareA: ~spareSeq, commandValue: val, writeCommand: cmd,
                 outputAndEnableBits: b, actionBits: a};
    imgValid = 1'b1;
    @(posedge mclk);
    #1;
    imgValid = 1'b0;
    img      = ~img;
  end
  endtask

  // Idle first, then the write code with its value in the next image, two clock cycles later.
  task automatic write_cmd(input logic [7:0] b, input logic [15:0] code, input logic [31:0] val);
  begin
    send(8'h00, b, cocd_pkg::CMD_IDLE, 32'h00000000);
    send(8'h00, b, code, val);
  end
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] EN = 8'h80;
  logic                   mclk;
  logic                   rst_b;
  logic                   chanMode;
  logic                   outputASetup;
  logic                   outputBSetup;
  logic                   imgValid;
  cocd_pkg::cocd_image_t  img;
  cocd_pkg::cocd_action_t action_q;
  logic                   adcStop_q;
  logic                   busControlEnable_q;
  logic                   switchOutputA_q;
  logic                   switchOutputB_q;
  logic                   switchOwnA_q;
  logic                   switchOwnB_q;
  cocd_pkg::cocd_write_t  write_q;
  int                     errTotal;
  int                     testsRun;
  cocd_pkg::cocd_write_t  expWr;

  always #20 mclk = ~mclk;

  cocd_plc_model u_plc (.mclk(mclk), .imgValid(imgValid), .img(img));

  cocd_block_decoder u_dut (
    .mclk(mclk), .rst_b(rst_b), .chanMode(chanMode), .imgValid(imgValid), .img(img),
    .outputASetup(outputASetup), .outputBSetup(outputBSetup), .action_q(action_q),
    .adcStop_q(adcStop_q), .busControlEnable_q(busControlEnable_q),
    .switchOutputA_q(switchOutputA_q), .switchOutputB_q(switchOutputB_q),
    .switchOwnA_q(switchOwnA_q), .switchOwnB_q(switchOwnB_q), .write_q(write_q)
  );

  // ****************************************************************
  // Comparisons
  // ****************************************************************
  task automatic completeRun;
  begin
    if (errTotal == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task automatic chkAct(input logic [6:0] exp);
  begin
    testsRun++;
    if (action_q !== exp)
    begin
      errTotal++;
      $display("ERROR %0t action pulses %h expected %h", $time, action_q, exp);
    end
  end
  endtask

  task automatic chkWr(input cocd_pkg::cocd_write_t exp);
  begin
    testsRun++;
    if (write_q !== exp)
    begin
      errTotal++;
      $display("ERROR %0t value write %h expected %h", $time, write_q, exp);
    end
  end
  endtask

  task automatic chkLvl(input logic got, input logic exp);
  begin
    testsRun++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR %0t level %b expected %b", $time, got, exp);
    end
  end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_tare;
  begin
    u_plc.send(8'h01, EN, 16'h0000, 32'h0);
    chkAct(7'h40);
    u_plc.send(8'h01, EN, 16'h0000, 32'h0);
    chkAct(7'h00);
    u_plc.send(8'h00, EN, 16'h0000, 32'h0);
  end
  endtask

  task automatic t_actions(input logic chan, input logic [6:0] ext);
    logic [6:0] exp [4];
  begin
    exp = '{7'h20, ext, 7'h04, 7'h02};
    chanMode = chan;
    for (int i = 0; i < 4; i++)
    begin
      u_plc.send(8'h02 << i, EN, 16'h0000, 32'h0);
      chkAct(exp[i]);
      u_plc.send(8'h00, EN, 16'h0000, 32'h0);
    end
  end
  endtask

  task automatic t_unused;
  begin
    chanMode = 1'b0;
    u_plc.send(8'he0, EN | 8'h79, 16'h0000, 32'h0);
    chkAct(7'h00);
    chkLvl(adcStop_q, 1'b0);
  end
  endtask

  task automatic t_channel;
  begin
    chanMode = 1'b1;
    repeat (2)
    begin
      u_plc.send(8'h00, EN | 8'h01, 16'h0000, 32'h0);
      chkAct(7'h01);
    end
    u_plc.send(8'h80, EN, 16'h0000, 32'h0);
    chkLvl(adcStop_q, 1'b1);
    u_plc.send(8'h00, EN, 16'h0000, 32'h0);
    chkLvl(adcStop_q, 1'b0);
  end
  endtask

  task automatic t_switch;
  begin
    outputASetup = 1'b1;
    u_plc.send(8'h00, EN | 8'h06, 16'h0000, 32'h0);
    chkLvl(switchOutputA_q, 1'b1);
    chkLvl(switchOwnA_q, 1'b1);
    chkLvl(busControlEnable_q, 1'b1);
    chkLvl(switchOwnB_q, 1'b0);
    chkLvl(switchOutputB_q, 1'b0);
    outputBSetup = 1'b1;
    u_plc.send(8'h00, EN | 8'h04, 16'h0000, 32'h0);
    chkLvl(switchOutputB_q, 1'b1);
    chkLvl(switchOwnB_q, 1'b1);
    chkLvl(switchOutputA_q, 1'b0);
  end
  endtask

  task automatic t_disabled;
  begin
    u_plc.send(8'h01, 8'h02, 16'h0000, 32'h0);
    chkAct(7'h00);
    chkLvl(busControlEnable_q, 1'b0);
    chkLvl(switchOwnB_q, 1'b0);
    chkLvl(switchOutputB_q, 1'b1);
    u_plc.send(8'h01, EN, 16'h0000, 32'h0);
    chkAct(7'h00);
    u_plc.write_cmd(8'h00, cocd_pkg::CMD_LOWA_U, 32'h12345678);
    chkWr(expWr);
    u_plc.send(8'h00, EN, 16'h0000, 32'h0);
  end
  endtask

  task automatic t_cmds(input logic chan);
    logic [31:0] val;
    logic        ok;
  begin
    chanMode = chan;
    for (int c = 1; c <= 9; c++)
    begin
      val = 32'h3f800000 + c + (chan << 8);
      ok  = chan || c == 1 || c[0] == 1'b0;
      u_plc.write_cmd(EN, c[15:0], val);
      expWr.write = ok;
      if (ok)
      begin
        expWr.target = cocd_pkg::cocd_target_t'(c[3:0]);
        expWr.value  = val;
      end
      chkWr(expWr);
      u_plc.send(8'h00, EN, c[15:0], ~val);
      expWr.write = 1'b0;
      chkWr(expWr);
      u_plc.send(8'h00, EN, cocd_pkg::CMD_IDLE, 32'h0);
    end
  end
  endtask

  initial
  begin
    #(40 * 5000);
    errTotal++;
    completeRun();
  end

  initial
  begin
    mclk         = 1'b0;
    rst_b        = 1'b0;
    chanMode     = 1'b0;
    outputASetup = 1'b0;
    outputBSetup = 1'b0;
    errTotal     = 0;
    testsRun     = 0;
    expWr        = '0;
    repeat (2) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chkAct(7'h00);
    chkWr(expWr);
    t_tare();
    t_actions(1'b0, 7'h10);
    t_unused();
    t_switch();
    t_disabled();
    t_cmds(1'b0);
    t_actions(1'b1, 7'h18);
    t_channel();
    t_cmds(1'b1);
    completeRun();
  end
endmodule
